// ### rtl/wdg_defines.vh
/*
 Constants for the digital watchdog downcounter: register offsets, field
 positions, reset values and timing counts. Definitions only.
*/
`ifndef WDG_DEFINES_VH
`define WDG_DEFINES_VH

// Byte addresses on the APB
`define WDG_ADDR_CNT 8'hd8
`define WDG_ADDR_STAT 8'hdc

// Count/control register fields
`define WDG_BIT_ACT 0
`define WDG_BIT_SR 1
`define WDG_PER_LO 2
`define WDG_PER_HI 7
`define WDG_REG_RESET 8'hfe
`define WDG_CNT_RESET 7'h7f
`define WDG_CNT_MSB 6

// Status register fields
`define WDG_ST_ACTIVE 0
`define WDG_ST_HWOPT 1
`define WDG_ST_WDRST 2
`define WDG_ST_STOP 3
`define WDG_ST_WAIT 4

// Timing, in oscillator (pclk) cycles
`define WDG_OSC_DIV 12
`define WDG_STEP_OSC_CYCLES 3072
`define WDG_PRESC_STEPS (`WDG_STEP_OSC_CYCLES / `WDG_OSC_DIV)
`define WDG_PRESC_LAST 8'hff
`define WDG_STAB_CYCLES 2048
`define WDG_STAB_LAST 11'h7ff

`endif

// ### rtl/wdg_clkdiv.v
/*
 Divide-by-N enable generator: one-cycle tick every DIV cycles of clk.
 Assumes a single clock; freeze holds the phase, clear restarts it.
*/
`timescale 1ns/1ps
module wdg_clkdiv #(
    parameter DIV = 12,
    parameter W = 4
) (
    input wire clk,
    input wire rst_n,
    input wire run,
    input wire clear,
    output reg tick
);
    reg [W-1:0] cnt_reg;
    wire at_end = (cnt_reg == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1});

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b0;
        end else if (clear) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b0;
        end else if (run) begin
            cnt_reg <= at_end ? {W{1'b0}} : cnt_reg + {{(W-1){1'b0}}, 1'b1};
            tick <= at_end;
        end else begin
            tick <= 1'b0;
        end
    end
endmodule // wdg_clkdiv

// ### rtl/wdg_top.v
/*
 Digital watchdog downcounter with APB register access.
 Assumes: one clock pclk at 125 MHz taken as the oscillator clock; the
 hardware-activation option strap is stable at and after reset release;
 stop_req, wait_req and wake_irq are one-cycle pulses from the core.
*/
`timescale 1ns/1ps
`include "wdg_defines.vh"

// Function
// - Chip reset when the counter top stage falls to zero while active.
// - Software option: inactive until activation bit set; stop mode usable only until then, stop acts as wait once active.
// - Once active, writes cannot deactivate; only a chip reset does.
// - Hardware option: stop acts as wait, oscillator runs, counting continues.
// - Leaving stop on an interrupt resumes counting from the held value.
// - Reset value: activation bit zero, period and self-reset bits one.
// - Writing the self-reset bit to zero causes an immediate chip reset.
// - Period bits reversed: register bit 7 is counter bit 0, bit 2 is bit 5.
// - Period bits select 64 timeouts from 3072 to 196608 oscillator cycles.
// - Hardware option: activation bit reads one and cannot be changed.
// - Inactive counter runs as free 7-bit timer and raises no reset.
// - At least 28 instructions run after activation before any reset.
// - Counter clocked from the oscillator divided by twelve.
// - Watchdog reset reinitialises counter, restarts chip with stabilisation delay.
module wdg_top #(
    parameter ADDR_W = 8,
    parameter STAB_CYCLES = `WDG_STAB_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire hw_option,
    input wire stop_req,
    input wire wait_req,
    input wire wake_irq,
    output reg chip_rst,
    output reg stop_mode,
    output reg wait_mode,
    output reg osc_run,
    output reg wdg_active
);
    // Counter state; bit 6 is the self-reset stage
    reg [6:0] cnt_reg;
    reg [6:0] cnt_next;
    reg act_reg;
    reg hwopt_reg;
    reg opt_valid_reg;
    reg wdrst_flag_reg;
    reg [7:0] presc_reg;
    reg [10:0] stab_reg;
    reg stab_busy_reg;
    reg step;
    reg fire;

    wire active = act_reg | hwopt_reg;
    wire frozen = stop_mode | stab_busy_reg;
    wire div_tick;

    // APB decode
    wire access = psel & penable;
    wire done = access & pready;
    wire hit_cnt = (paddr == `WDG_ADDR_CNT);
    wire hit_stat = (paddr == `WDG_ADDR_STAT);
    wire mapped = hit_cnt | hit_stat;
    wire wr_cnt = done & pwrite & hit_cnt & pstrb[0];
    wire wr_stat = done & pwrite & hit_stat & pstrb[0];
    wire act_rise = wr_cnt & pwdata[`WDG_BIT_ACT] & ~active & ~hwopt_reg;

    // Reversed mapping between register bits and counter stages
    reg [7:0] cnt_view;
    reg [6:0] cnt_load;
    integer i;
    always @* begin
        cnt_view = 8'h00;
        cnt_load = 7'h00;
        for (i = 0; i < 6; i = i + 1) begin
            cnt_view[`WDG_PER_HI - i] = cnt_reg[i];
            cnt_load[i] = pwdata[`WDG_PER_HI - i];
        end
        cnt_view[`WDG_BIT_SR] = cnt_reg[`WDG_CNT_MSB];
        cnt_view[`WDG_BIT_ACT] = active;
        cnt_load[`WDG_CNT_MSB] = pwdata[`WDG_BIT_SR];
    end

    // Divide-by-twelve enable; halted while the oscillator is stopped
    wdg_clkdiv #(
        .DIV(`WDG_OSC_DIV),
        .W(4)
    ) u_div (
        .clk(pclk),
        .rst_n(presetn),
        .run(~frozen),
        .clear(wr_cnt | stab_busy_reg),
        .tick(div_tick)
    );

    // Counter next value and reset trigger
    always @* begin
        cnt_next = cnt_reg;
        step = div_tick & (presc_reg == `WDG_PRESC_LAST) & ~frozen;
        fire = 1'b0;
        if (wr_cnt) begin
            cnt_next = cnt_load;
            if (!pwdata[`WDG_BIT_SR])
                fire = 1'b1;
        end else if (step) begin
            cnt_next = cnt_reg - 7'h01;
            if (active && cnt_reg[`WDG_CNT_MSB] && !cnt_next[`WDG_CNT_MSB])
                fire = 1'b1;
        end
    end

    // Option strap caught after reset release
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_valid_reg <= 1'b0;
            hwopt_reg <= 1'b0;
        end else if (!opt_valid_reg) begin
            opt_valid_reg <= 1'b1;
            hwopt_reg <= hw_option;
        end
    end

    // Prescaler: 256 divided ticks per counter step
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            presc_reg <= 8'h00;
        else if (stab_busy_reg || wr_cnt || act_rise)
            presc_reg <= 8'h00;
        else if (div_tick && !frozen)
            presc_reg <= presc_reg + 8'h01;
    end

    // Counter and activation bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= `WDG_CNT_RESET;
            act_reg <= 1'b0;
        end else if (stab_busy_reg || fire) begin
            cnt_reg <= `WDG_CNT_RESET;
            act_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            if (act_rise)
                act_reg <= 1'b1;
        end
    end

    // Stabilisation delay after a watchdog reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_busy_reg <= 1'b0;
            stab_reg <= 11'h000;
            chip_rst <= 1'b0;
        end else if (fire && !stab_busy_reg) begin
            stab_busy_reg <= 1'b1;
            stab_reg <= 11'h000;
            chip_rst <= 1'b1;
        end else if (stab_busy_reg) begin
            if (stab_reg == STAB_CYCLES[10:0] - 11'h001) begin
                stab_busy_reg <= 1'b0;
                chip_rst <= 1'b0;
            end else begin
                stab_reg <= stab_reg + 11'h001;
            end
        end
    end

    // Power modes: stop only while the watchdog is inactive
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_mode <= 1'b0;
            wait_mode <= 1'b0;
            osc_run <= 1'b1;
        end else if (stab_busy_reg || fire || wake_irq) begin
            stop_mode <= 1'b0;
            wait_mode <= 1'b0;
            osc_run <= 1'b1;
        end else if (stop_req) begin
            if (active) begin
                wait_mode <= 1'b1;
                osc_run <= 1'b1;
            end else begin
                stop_mode <= 1'b1;
                osc_run <= 1'b0;
            end
        end else if (wait_req) begin
            wait_mode <= 1'b1;
        end
    end

    // Sticky watchdog-reset flag, cleared by writing one; a new reset wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wdrst_flag_reg <= 1'b0;
        else if (fire)
            wdrst_flag_reg <= 1'b1;
        else if (wr_stat && pwdata[`WDG_ST_WDRST])
            wdrst_flag_reg <= 1'b0;
    end

    // Active indication
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wdg_active <= 1'b0;
        else
            wdg_active <= active & ~stab_busy_reg & ~fire;
    end

    // APB slave: one wait state, registered answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (access && !pready) begin
            pready <= 1'b1;
            pslverr <= ~mapped;
            if (!pwrite && hit_cnt)
                prdata <= {24'h000000, cnt_view};
            else if (!pwrite && hit_stat)
                prdata <= {27'h0000000, wait_mode, stop_mode, wdrst_flag_reg,
                           hwopt_reg, active};
            else
                prdata <= 32'h0000_0000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // wdg_top

// ### tb/wdg_chk.sv
/* Concurrent checks on the ports of wdg_top.
   Assumes one APB wait state and a chip reset held at least 9 cycles. */
`timescale 1ns/1ps
module wdg_chk #(
    parameter ADDR_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire pready,
    input wire pslverr,
    input wire hw_option,
    input wire stop_req,
    input wire wake_irq,
    input wire chip_rst,
    input wire stop_mode,
    input wire wait_mode,
    input wire wdg_active
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    rdy_wait_a: assert property ($rose(psel && penable) |=> pready)
        else $error("late pready");
    bad_addr_a: assert property (pready && paddr != 'hd8 && paddr != 'hdc |-> pslverr)
        else $error("no error flag");
    sr_write_a: assert property (pready && pwrite && pstrb[0] && paddr == 'hd8 && !pwdata[1]
        |-> ##[1:2] chip_rst) else $error("no self reset");
    rst_hold_a: assert property ($rose(chip_rst) |=> chip_rst [*8])
        else $error("short chip reset");
    act_keep_a: assert property (wdg_active && !chip_rst |=> wdg_active || chip_rst)
        else $error("watchdog deactivated");
    hw_act_a: assert property ((hw_option && !chip_rst) [*4] |-> wdg_active)
        else $error("hardware option inactive");
    stop_sw_a: assert property (stop_req && !hw_option && !wdg_active && !chip_rst
        |=> stop_mode) else $error("stop refused");
    stop_hw_a: assert property (stop_req && hw_option && wdg_active |=> wait_mode && !stop_mode)
        else $error("stop not as wait");
    wake_a: assert property (wake_irq |=> !stop_mode && !wait_mode)
        else $error("no wake");
endmodule // wdg_chk

bind wdg_top wdg_chk #(.ADDR_W(ADDR_W)) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .hw_option(hw_option), .stop_req(stop_req),
    .wake_irq(wake_irq), .chip_rst(chip_rst), .stop_mode(stop_mode), .wait_mode(wait_mode),
    .wdg_active(wdg_active));

// ### tb/tb.sv
/* Self-checking bench for wdg_top over APB.
   Assumes one wait state per access and STAB_CYCLES set to 16. */
`timescale 1ns/1ps
module tb;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hw_option = 0;
    reg stop_req = 0, wait_req = 0, wake_irq = 0;
    reg [7:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg [3:0] pstrb = 4'hf;
    reg er;
    wire [31:0] prdata;
    wire pready, pslverr, chip_rst, stop_mode, wait_mode, osc_run, wdg_active;
    integer num_errors = 0, samples_checked = 0, n;
    wdg_top #(.STAB_CYCLES(16)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_option(hw_option),
        .stop_req(stop_req), .wait_req(wait_req), .wake_irq(wake_irq), .chip_rst(chip_rst),
        .stop_mode(stop_mode), .wait_mode(wait_mode), .osc_run(osc_run), .wdg_active(wdg_active));
    initial forever #4 pclk = ~pclk;
    task report_and_stop;
        begin
            $display("mismatches %0d checks %0d", num_errors, samples_checked);
            if (num_errors == 0 && samples_checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task hang(input integer lim);
        if (n >= lim) begin
            num_errors = num_errors + 1;
            report_and_stop;
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge pclk);
            end
            hang(20);
            rd = prdata;
            er = pslverr;
            psel <= 0;
            penable <= 0;
            @(posedge pclk);
        end
    endtask
    task wait_rst(input v, input integer lim);
        begin
            n = 0;
            while (chip_rst !== v && n < lim) begin
                n = n + 1;
                @(posedge pclk);
            end
            hang(lim);
        end
    endtask
    task pulse(input s);
        begin
            if (s) stop_req <= 1;
            else wake_irq <= 1;
            @(posedge pclk);
            stop_req <= 0;
            wake_irq <= 0;
            @(posedge pclk);
        end
    endtask
    task do_reset(input hw);
        begin
            presetn <= 0;
            hw_option <= hw;
            repeat (8) @(posedge pclk);
            presetn <= 1;
            repeat (3) @(posedge pclk);
        end
    endtask
    task t_timer;
        begin
            apb(0, 8'hd8, 0);
            chk(rd, 32'hfe);
            apb(0, 8'h10, 0);
            chk({31'h0, er}, 32'h1);
            apb(1, 8'hd8, 32'h02);
            wait_req <= 1;
            @(posedge pclk);
            wait_req <= 0;
            @(posedge pclk);
            chk({31'h0, wait_mode}, 32'h1);
            apb(0, 8'hdc, 0);
            chk(rd, 32'h10);
            pulse(0);
            chk({31'h0, wait_mode}, 32'h0);
            repeat (3100) @(posedge pclk);
            chk({31'h0, chip_rst}, 32'h0);
            apb(0, 8'hd8, 0);
            chk(rd, 32'hfc);
        end
    endtask
    task t_stop;
        begin
            apb(1, 8'hd8, 32'h02);
            pulse(1);
            chk({stop_mode, osc_run}, 32'h2);
            repeat (3200) @(posedge pclk);
            pulse(0);
            chk({stop_mode, osc_run}, 32'h1);
            apb(0, 8'hd8, 0);
            chk(rd, 32'h02);
        end
    endtask
    task t_act;
        begin
            apb(1, 8'hd8, 32'h03);
            apb(1, 8'hd8, 32'h02);
            apb(0, 8'hd8, 0);
            chk(rd, 32'h03);
            wait_rst(1, 4000);
            chk(n > 3050 && n < 3080, 32'h1);
            wait_rst(0, 100);
            chk(n > 13 && n < 19, 32'h1);
            apb(0, 8'hd8, 0);
            chk(rd, 32'hfe);
            apb(1, 8'hd8, 32'h00);
            wait_rst(1, 3);
            wait_rst(0, 100);
            apb(0, 8'hd8, 0);
            chk(rd, 32'hfe);
            apb(0, 8'hdc, 0);
            chk(rd, 32'h04);
            apb(1, 8'hdc, 32'h04);
            apb(0, 8'hdc, 0);
            chk(rd, 32'h00);
        end
    endtask
    task t_hw;
        begin
            do_reset(1);
            apb(1, 8'hd8, 32'hfe);
            apb(0, 8'hd8, 0);
            chk(rd, 32'hff);
            pulse(1);
            chk({stop_mode, wait_mode, osc_run}, 32'h3);
            pulse(0);
        end
    endtask
    initial begin
        do_reset(0);
        t_timer;
        t_stop;
        t_act;
        t_hw;
        report_and_stop;
    end
endmodule // tb
